// ### src/cta_pkg.sv
// Purpose: shared constants of the counter array timebase
// Assumes: one system clock, 10 MHz
// Notes: timebase codes follow the three-bit select field
package cta_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W = 3;
    localparam int PRESC_W = 4;
    localparam int EXT_W = 3;
    localparam int NUM_MODULES = 6;

    // ****************************************
    // timebase select codes
    // ****************************************
    typedef enum logic [SEL_W-1:0] {
        CTA_TB_DIV12 = 3'h0,
        CTA_TB_DIV4 = 3'h1,
        CTA_TB_TIMER0 = 3'h2,
        CTA_TB_EXT_IN = 3'h3,
        CTA_TB_SYSCLK = 3'h4,
        CTA_TB_OSC_DIV8 = 3'h5
    } cta_timebase_type;

    // ****************************************
    // divisors and reset values
    // ****************************************
    localparam int SLOW_DIV = 12;
    localparam int FAST_DIV = 4;
    localparam int OSC_DIV = 8;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;
    localparam logic [PRESC_W-1:0] PRESC_ONE = 4'h1;
    localparam logic [EXT_W-1:0] EXT_RESET = 3'h0;
    localparam logic [EXT_W-1:0] EXT_ONE = 3'h1;

endpackage

// ### src/cta_edge_sync.sv
// Purpose: two-flop synchroniser with edge detection
// Assumes: sig_in may be asynchronous to clk_in
// Notes: edges are one-cycle pulses, one to two cycles late
`timescale 1ns/1ps
`default_nettype none

module cta_edge_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // sampled level
    input wire logic sig_in,
    // edge pulses
    output logic rise_out,
    output logic fall_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    // ****************************************
    // synchroniser and history
    // ****************************************
    always_comb begin
        meta_d = sig_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // only the second stage and its delayed copy feed the detectors
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;

endmodule // cta_edge_sync

`default_nettype wire

// ### src/cta_timebase.sv
// Purpose: 16-bit counter of the counter array with selectable timebase
// Assumes: byte read/write strobes are one-cycle pulses from the core
// Notes: flag and interrupt gating included; capture modules tap count
//
// Behaviour
// [RULE1] Counter is 16 bits, seen as a high byte and a low byte.
// [RULE2] Low byte read latches high byte; next high read returns that copy.
// [RULE3] Byte reads never disturb counting.
// [RULE4] Select picks sysclk/12, /4, timer0, ext falling, sysclk, osc/8.
// [RULE5] External input counts falling edges; source at most sysclk/4.
// [RULE6] Oscillator divided by eight is synchronised before use.
// [RULE7] Wrap from all ones to zero sets the overflow flag.
// [RULE8] Overflow requests interrupt only while flag and its enable are set.
// [RULE9] Vectoring never clears the flag; software clears it.
// [RULE10] Requests leave only with global and array enables both set.
// [RULE11] Idle halt control low keeps counting through processor idle.
// [RULE12] Wrap during control register rmw leaves the flag unset.
// [RULE13] Software brackets bit operations with counter reads and fixes flag.
// [RULE14] Count value goes to six 16-bit capture/compare modules.
// [RULE15] Each timebase tick adds exactly one, synchronous to system clock; the code drops a tick that meets a byte write.
// [RULE16] Idle halt control high freezes counter while processor idles.
`timescale 1ns/1ps
`default_nettype none

module cta_timebase #(
    parameter int SLOW_DIVISOR = cta_pkg::SLOW_DIV,
    parameter int FAST_DIVISOR = cta_pkg::FAST_DIV,
    parameter int OSC_DIVISOR = cta_pkg::OSC_DIV,
    parameter int MODULE_COUNT = cta_pkg::NUM_MODULES
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // counter byte access
    input wire logic low_rd_in,
    input wire logic high_rd_in,
    input wire logic low_wr_in,
    input wire logic high_wr_in,
    input wire logic [cta_pkg::BYTE_W-1:0] wr_data_in,
    output logic [cta_pkg::BYTE_W-1:0] rd_data_out,
    // mode control
    input wire logic [cta_pkg::SEL_W-1:0] timebase_select_in,
    input wire logic idle_halt_control_in,
    input wire logic cpu_idle_in,
    // timebase sources
    input wire logic timer0_overflow_in,
    input wire logic external_count_input_in,
    input wire logic ext_osc_in,
    // overflow flag
    input wire logic flag_wr_in,
    input wire logic flag_wr_data_in,
    input wire logic control_rmw_in,
    output logic count_overflow_flag_out,
    // interrupt enables and request
    input wire logic overflow_irq_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    input wire logic [cta_pkg::NUM_MODULES-1:0] module_match_flag_in,
    output logic array_irq_out,
    // count shared with capture/compare modules
    output logic [cta_pkg::COUNT_W-1:0] count_value_out,
    output logic count_tick_out
);
    import cta_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (SLOW_DIVISOR < 2 || SLOW_DIVISOR > (1 << PRESC_W)) begin : g_bad_slow
        $error("slow divisor out of range");
    end
    if (FAST_DIVISOR < 2 || FAST_DIVISOR > (1 << PRESC_W)) begin : g_bad_fast
        $error("fast divisor out of range");
    end
    if (OSC_DIVISOR < 2 || OSC_DIVISOR > (1 << EXT_W)) begin : g_bad_osc
        $error("oscillator divisor out of range");
    end
    if (MODULE_COUNT != NUM_MODULES) begin : g_bad_mods
        $error("module count must match match flag width");
    end

    localparam logic [PRESC_W-1:0] SLOW_LAST = PRESC_W'(SLOW_DIVISOR - 1);
    localparam logic [PRESC_W-1:0] FAST_LAST = PRESC_W'(FAST_DIVISOR - 1);
    localparam logic [EXT_W-1:0] OSC_LAST = EXT_W'(OSC_DIVISOR - 1);

    cta_timebase_type sel;
    logic run;
    logic eci_fall;
    logic osc_rise;
    logic tick;
    logic wrap;

    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic presc_tick;
    logic [PRESC_W-1:0] presc_last;
    logic [EXT_W-1:0] osc_q;
    logic [EXT_W-1:0] osc_d;
    logic osc_tick;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic tick_q;
    logic tick_d;
    logic [BYTE_W-1:0] snap_q;
    logic [BYTE_W-1:0] snap_d;
    logic [BYTE_W-1:0] rd_q;
    logic [BYTE_W-1:0] rd_d;
    logic flag_q;
    logic flag_d;
    logic irq_q;
    logic irq_d;
    logic ovf_req;
    logic match_req;

    assign sel = cta_timebase_type'(timebase_select_in);

    // [RULE11] idle keeps running
    // [RULE16] idle halt freezes
    assign run = ~(cpu_idle_in & idle_halt_control_in);

    // ****************************************
    // edge synchronisers
    // ****************************************
    // [RULE5] falling edges counted
    cta_edge_sync u_eci_sync (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .sig_in(external_count_input_in),
        .rise_out(),
        .fall_out(eci_fall)
    );

    // [RULE6] oscillator synchronised first
    cta_edge_sync u_osc_sync (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .sig_in(ext_osc_in),
        .rise_out(osc_rise),
        .fall_out()
    );

    // ****************************************
    // prescalers
    // ****************************************
    // one counter serves both sysclk dividers; it restarts on a select
    // change only through the wrap test, which costs at most one period
    always_comb begin
        presc_d = presc_q;
        presc_tick = 1'b0;
        presc_last = (sel == CTA_TB_DIV12) ? SLOW_LAST : FAST_LAST;
        if (run && (sel == CTA_TB_DIV12 || sel == CTA_TB_DIV4)) begin
            if (presc_q >= presc_last) begin
                presc_d = PRESC_RESET;
                presc_tick = 1'b1;
            end else begin
                presc_d = presc_q + PRESC_ONE;
            end
        end
        osc_d = osc_q;
        osc_tick = 1'b0;
        if (run && osc_rise) begin
            if (osc_q >= OSC_LAST) begin
                osc_d = EXT_RESET;
                osc_tick = 1'b1;
            end else begin
                osc_d = osc_q + EXT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            presc_q <= PRESC_RESET;
            osc_q <= EXT_RESET;
        end else begin
            presc_q <= presc_d;
            osc_q <= osc_d;
        end
    end

    // ****************************************
    // timebase select
    // ****************************************
    // [RULE4] timebase multiplexer
    always_comb begin
        unique case (sel)
            CTA_TB_DIV12: tick = presc_tick;
            CTA_TB_DIV4: tick = presc_tick;
            CTA_TB_TIMER0: tick = timer0_overflow_in & run;
            CTA_TB_EXT_IN: tick = eci_fall & run;
            CTA_TB_SYSCLK: tick = run;
            CTA_TB_OSC_DIV8: tick = osc_tick;
            // unused codes stop the counter
            default: tick = 1'b0;
        endcase
    end

    // ****************************************
    // main counter
    // ****************************************
    // [RULE7] wrap detection
    assign wrap = tick && !low_wr_in && !high_wr_in && (count_q == COUNT_MAX);

    // software byte writes win over a tick in the same cycle
    always_comb begin
        count_d = count_q;
        tick_d = 1'b0;
        if (low_wr_in || high_wr_in) begin
            if (low_wr_in) begin
                count_d[BYTE_W-1:0] = wr_data_in;
            end
            if (high_wr_in) begin
                count_d[COUNT_W-1:BYTE_W] = wr_data_in;
            end
        end else if (tick) begin
            // [RULE15] increment by one
            count_d = count_q + COUNT_ONE;
            tick_d = 1'b1;
        end
    end

    // [RULE1] 16-bit counter register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= COUNT_RESET;
            tick_q <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q <= tick_d;
        end
    end

    // ****************************************
    // byte reads and snapshot
    // ****************************************
    // reads only touch the snapshot and read data, never the counter
    // a high read with no low read first returns a stale copy
    always_comb begin
        snap_d = snap_q;
        rd_d = rd_q;
        // [RULE2] low read latches high
        if (low_rd_in) begin
            snap_d = count_q[COUNT_W-1:BYTE_W];
            rd_d = count_q[BYTE_W-1:0];
        end else if (high_rd_in) begin
            // [RULE3] reads leave counting alone
            rd_d = snap_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            snap_q <= BYTE_RESET;
            rd_q <= BYTE_RESET;
        end else begin
            snap_q <= snap_d;
            rd_q <= rd_d;
        end
    end

    // ****************************************
    // overflow flag and interrupt
    // ****************************************
    // outside a control rmw, a wrap beats a software clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        // [RULE9] cleared by software only
        if (flag_wr_in) begin
            flag_d = flag_wr_data_in;
        end
        // [RULE12] lost during control rmw
        if (wrap && !control_rmw_in) begin
            flag_d = 1'b1;
        end
        // [RULE8] overflow request gated
        ovf_req = flag_q & overflow_irq_enable_in;
        match_req = |module_match_flag_in;
        // [RULE10] global and array enables
        irq_d = (ovf_req | match_req) & global_irq_enable_in
            & array_irq_enable_in;
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // registered requests trail the flag by one cycle
    assign rd_data_out = rd_q;
    assign count_overflow_flag_out = flag_q;
    assign array_irq_out = irq_q;
    // [RULE14] count shared by modules
    assign count_value_out = count_q;
    assign count_tick_out = tick_q;

endmodule // cta_timebase

`default_nettype wire

// ### sim/cta_source_model.sv
// Purpose: outside sources feeding the timebase inputs
// Assumes: free-running sources, no handshake with the core
// Notes: oscillator 4 MHz, slow enough to be sampled every edge
`timescale 1ns/1ps
`default_nettype none

module cta_source_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // generated sources
    output logic timer0_overflow_out,
    output logic external_count_out,
    output var logic ext_osc_out
);
    // ****************************************
    // periodic sources
    // ****************************************
    logic [2:0] t_q;
    logic [2:0] e_q;
    initial ext_osc_out = 1'b0;
    always #125 ext_osc_out = ~ext_osc_out;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            t_q <= 3'h0;
            e_q <= 3'h0;
        end else begin
            t_q <= (t_q == 3'h4) ? 3'h0 : t_q + 3'h1;
            e_q <= e_q + 3'h1;
        end
    end
    assign timer0_overflow_out = (t_q == 3'h4);
    assign external_count_out = e_q[2];
endmodule // cta_source_model

`default_nettype wire

// ### sim/cta_timebase_checker.sv
// Purpose: port timing checks of the counter array timebase
// Assumes: sees only the ports of cta_timebase
// Notes: writes drop the tick of their cycle
`timescale 1ns/1ps
`default_nettype none

module cta_timebase_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // access and control
    input wire logic low_rd_in,
    input wire logic high_rd_in,
    input wire logic low_wr_in,
    input wire logic high_wr_in,
    input wire logic [cta_pkg::SEL_W-1:0] timebase_select_in,
    input wire logic idle_halt_control_in,
    input wire logic cpu_idle_in,
    input wire logic flag_wr_in,
    input wire logic control_rmw_in,
    input wire logic overflow_irq_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic array_irq_enable_in,
    // observed outputs
    input wire logic [cta_pkg::BYTE_W-1:0] rd_data_out,
    input wire logic count_overflow_flag_out,
    input wire logic array_irq_out,
    input wire logic [cta_pkg::COUNT_W-1:0] count_value_out,
    input wire logic count_tick_out
);
    import cta_pkg::*;
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic wr_any;
    logic frozen;
    assign wr_any = low_wr_in | high_wr_in;
    assign frozen = idle_halt_control_in & cpu_idle_in;
    sequence s_wrap;
        $past(count_value_out) == COUNT_MAX &&
            count_value_out == COUNT_RESET && count_tick_out;
    endsequence
    sequence s_rd_pair;
        low_rd_in ##1 (high_rd_in && !low_rd_in);
    endsequence
    AST_STEP: assert property (count_tick_out |->
        count_value_out == 16'($past(count_value_out) + COUNT_ONE))
        else $error("bad step");
    AST_HOLD: assert property (!count_tick_out && !$past(wr_any) &&
        $past(reset_n_in) |-> $stable(count_value_out))
        else $error("count moved without tick");
    AST_SYSCLK: assert property (!frozen && !wr_any &&
        timebase_select_in == CTA_TB_SYSCLK |=> count_tick_out)
        else $error("no sysclk tick");
    AST_FREEZE: assert property (frozen |=> !count_tick_out)
        else $error("tick while halted");
    AST_RD_LOW: assert property (low_rd_in |=>
        rd_data_out == $past(count_value_out[7:0])) else $error("low read");
    AST_SNAP: assert property (s_rd_pair |=>
        rd_data_out == $past(count_value_out[15:8], 2))
        else $error("snapshot read");
    AST_FLAG_SET: assert property (s_wrap ##0 !$past(control_rmw_in)
        |-> count_overflow_flag_out) else $error("wrap not flagged");
    AST_RMW: assert property (s_wrap ##0 ($past(control_rmw_in) &&
        !$past(count_overflow_flag_out) && !$past(flag_wr_in))
        |-> !count_overflow_flag_out) else $error("flag set in rmw");
    AST_STICKY: assert property (count_overflow_flag_out &&
        !flag_wr_in |=> count_overflow_flag_out) else $error("flag lost");
    AST_IRQ: assert property (count_overflow_flag_out &&
        overflow_irq_enable_in && global_irq_enable_in &&
        array_irq_enable_in |=> array_irq_out) else $error("no request");
    AST_GATE: assert property (!(global_irq_enable_in &&
        array_irq_enable_in) |=> !array_irq_out) else $error("ungated");
endmodule // cta_timebase_checker

`default_nettype wire

// ### sim/cta_timebase_tb_top.sv
// Purpose: directed tests of the counter array timebase
// Assumes: select 6 stops counting between steps
// Notes: windows span whole tick periods so prescaler phase cancels
`timescale 1ns/1ps
`default_nettype none

module cta_timebase_tb_top;
    import cta_pkg::*;
    // ****************************************
    // bench
    // ****************************************
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic low_rd, high_rd, low_wr, high_wr, halt, idle, fwr, fdat, rmw;
    logic ecf, ea, epca, irq, flag, tick, t0, external_count_input, osc;
    logic [7:0] wdat, rdat;
    logic [2:0] sel;
    logic [15:0] cnt, w;
    logic [5:0] mflag;
    int wins[7] = '{120, 40, 50, 80, 10, 200, 10};
    int num_errors = 0;
    int checked = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    cta_source_model u_cta_source_model (.ref_clk_in, .reset_n_in,
        .timer0_overflow_out(t0), .external_count_out(external_count_input),
        .ext_osc_out(osc));
    cta_timebase u_cta_timebase (.ref_clk_in, .reset_n_in,
        .low_rd_in(low_rd), .high_rd_in(high_rd), .low_wr_in(low_wr),
        .high_wr_in(high_wr), .wr_data_in(wdat), .rd_data_out(rdat),
        .timebase_select_in(sel), .idle_halt_control_in(halt),
        .cpu_idle_in(idle), .timer0_overflow_in(t0),
        .external_count_input_in(external_count_input), .ext_osc_in(osc),
        .flag_wr_in(fwr), .flag_wr_data_in(fdat), .control_rmw_in(rmw),
        .count_overflow_flag_out(flag), .overflow_irq_enable_in(ecf),
        .global_irq_enable_in(ea), .array_irq_enable_in(epca),
        .module_match_flag_in(mflag), .array_irq_out(irq),
        .count_value_out(cnt), .count_tick_out(tick));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wr16(input logic [15:0] v);
        cyc(1);
        low_wr <= 1'b1;
        wdat <= v[7:0];
        cyc(1);
        low_wr <= 1'b0;
        high_wr <= 1'b1;
        wdat <= v[15:8];
        cyc(1);
        high_wr <= 1'b0;
    endtask
    task automatic rd(input logic hi);
        cyc(1);
        low_rd <= !hi;
        high_rd <= hi;
        cyc(1);
        low_rd <= 1'b0;
        high_rd <= 1'b0;
    endtask
    task automatic rd2();
        cyc(1);
        low_rd <= 1'b1;
        cyc(1);
        low_rd <= 1'b0;
        high_rd <= 1'b1;
        cyc(1);
        high_rd <= 1'b0;
    endtask
    task automatic run(input logic [2:0] s, input int n);
        cyc(1);
        sel <= s;
        cyc(n);
        sel <= 3'h6;
        cyc(2);
    endtask
    task automatic fw(input logic v);
        cyc(1);
        fwr <= 1'b1;
        fdat <= v;
        cyc(1);
        fwr <= 1'b0;
        cyc(1);
    endtask
    task automatic final_report();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        {low_rd, high_rd, low_wr, high_wr, halt, idle, fwr, fdat} = '0;
        {rmw, ecf, ea, epca} = '0;
        wdat = 8'h00;
        mflag = 6'h00;
        sel = 3'h6;
        cyc(5);
        reset_n_in <= 1'b1;
        chk(cnt, COUNT_RESET);
        wr16(16'h12FF);
        rd(1'b0);
        chk(16'(rdat), 16'h00FF);
        run(3'h4, 3);
        chk(cnt, 16'h1302);
        rd(1'b1);
        chk(16'(rdat), 16'h0012);
        rd2();
        chk(16'(rdat), 16'h0013);
        idle <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            halt <= (i == 6);
            wr16(COUNT_RESET);
            run((i == 6) ? 3'h4 : 3'(i), wins[i]);
            w = (i == 6) ? COUNT_RESET : 16'h000A;
            chk(cnt, w);
        end
        {idle, halt} <= 2'b00;
        {ecf, ea, epca} <= 3'h7;
        wr16(COUNT_MAX);
        run(3'h4, 1);
        chk(cnt, COUNT_RESET);
        chk(16'({flag, irq}), 16'h0003);
        cyc(20);
        chk(16'(flag), 16'h0001);
        fw(1'b0);
        chk(16'({flag, irq}), 16'h0000);
        ea <= 1'b0;
        fw(1'b1);
        chk(16'(irq), 16'h0000);
        ea <= 1'b1;
        cyc(2);
        chk(16'(irq), 16'h0001);
        ecf <= 1'b0;
        cyc(2);
        chk(16'(irq), 16'h0000);
        fw(1'b0);
        rmw <= 1'b1;
        wr16(COUNT_MAX);
        rd2();
        chk(16'(rdat), 16'h00FF);
        run(3'h4, 1);
        rmw <= 1'b0;
        chk(16'(flag), 16'h0000);
        rd2();
        chk(16'(rdat), 16'h0000);
        fw(1'b1);
        chk(16'(flag), 16'h0001);
        mflag <= 6'h20;
        cyc(2);
        chk(16'(irq), 16'h0001);
        epca <= 1'b0;
        cyc(2);
        chk(16'(irq), 16'h0000);
        final_report();
    end
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
endmodule // cta_timebase_tb_top

bind cta_timebase cta_timebase_checker u_cta_timebase_checker (
    .ref_clk_in, .reset_n_in, .low_rd_in, .high_rd_in, .low_wr_in,
    .high_wr_in, .timebase_select_in, .idle_halt_control_in, .cpu_idle_in,
    .flag_wr_in, .control_rmw_in, .overflow_irq_enable_in,
    .global_irq_enable_in, .array_irq_enable_in, .rd_data_out,
    .count_overflow_flag_out, .array_irq_out, .count_value_out,
    .count_tick_out);

`default_nettype wire
